// ---- shared/sumc_pkg.sv ----
package sumc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_MODE_CTRL = 10'h09a;
  localparam logic [9:0] IDX_DATA = 10'h09b;
  localparam logic [9:0] IDX_SLAVE_ADDR = 10'h0aa;
  localparam logic [9:0] IDX_ADDR_MASK = 10'h0ba;
  localparam logic [9:0] IDX_SEC_CTRL = 10'h08f;
  localparam logic [1:0] WORD_LANE = 2'h0;

  // Reset values
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [3:0] SEC_CTRL_RST = 4'h0;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
  localparam logic [7:0] ADDR_MASK_RST = 8'h00;
  localparam logic [7:0] RX_DATA_RST = 8'h00;
  localparam logic [23:0] RDATA_PAD = 24'h000000;
  localparam logic [3:0] SEC_RSVD = 4'h0;

  // Bit 7 of the mode control register is shared
  localparam int BIT_SHARED = 7;

  // Mode control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic mode_select_low;
    logic mode_select_high;
    logic multiproc_enable;
    logic receiver_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } sumc_ctrl_t;

  // Secondary serial control, bits 7 to 4
  typedef struct packed {
    logic double_rate_bit;
    logic alt_view_select;
    logic rx_timer2_sel;
    logic tx_timer2_sel;
  } sumc_sec_t;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_UART9F = 2'h2,
    MODE_UART9V = 2'h3
  } sumc_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_RUN = 2'b10
  } sumc_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } sumc_rx_t;

  // Divider end counts: shift clock is ref/12, fixed rate 16 samples/bit
  localparam logic [3:0] SHIFT_CLK_LAST = 4'hb;
  localparam logic [3:0] SHIFT_CLK_HALF = 4'h6;
  localparam logic [3:0] FIX_LAST_FAST = 4'h1;
  localparam logic [3:0] FIX_LAST_SLOW = 4'h3;
  localparam logic [3:0] DIV_ZERO = 4'h0;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;

  // Bit counts
  localparam logic [3:0] BITS_SHIFT = 4'h8;
  localparam logic [3:0] FRAME8 = 4'ha;
  localparam logic [3:0] FRAME9 = 4'hb;
  localparam logic [3:0] RX_LEFT8 = 4'h9;
  localparam logic [3:0] RX_LEFT9 = 4'ha;
  localparam logic [3:0] LEFT_STOP = 4'h1;
  localparam logic [3:0] LEFT_PRE_STOP = 4'h2;

endpackage

// ---- hw/sumc_fifo.sv ----
`timescale 1ns/1ps
module sumc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != CNT_FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wptr_reg] = in_data;
      wptr_next = (wptr_reg == PTR_LAST) ? '0 : wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = (rptr_reg == PTR_LAST) ? '0 : rptr_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

// ---- hw/sumc_top.sv ----
// Summary of operation
// RULE1 - Alternate view shows framing error at bit 7
// RULE2 - Framing error sticks until software clears it
// RULE3 - Normal view maps bit 7 to low mode
// RULE4 - Two mode bits pick one of four modes
// RULE5 - Fixed 9-bit mode runs at ref/32 or ref/64
// RULE6 - Bit 5 enables multiprocessor and address recognition
// RULE7 - Multiprocessor receiver separates commands and matches addresses
// RULE8 - Bit 4 enables receiver; clear means transmit only
// RULE9 - Bit 3 sent as ninth bit in 9-bit modes
// RULE10 - Mode control register resets to zero
// RULE11 - Transmit done set after last bit; software clears
// RULE12 - Receive done set after frame; software clears
// RULE13 - Bit 2 gets ninth bit or stop bit
// RULE14 - Double rate bit doubles timer-based baud rate; the code doubles the timer 1 rate only, timer 2 rates stay undoubled
// RULE15 - Frame: start, eight data LSB first, stop
// RULE16 - Multiprocessor receive done needs ninth bit or match
`timescale 1ns/1ps
module sumc_top #(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Baud rate sources
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Serial pins
  output logic second_tx_pin,
  input wire logic second_rx_pin_in,
  output logic second_rx_pin_out,
  output logic second_rx_pin_oe
);

  sumc_pkg::sumc_ctrl_t ctrl_reg, ctrl_next;
  sumc_pkg::sumc_sec_t sec_reg, sec_next;
  sumc_pkg::sumc_mode_t mode;
  logic fe_reg, fe_next;
  logic [7:0] saddr_reg, saddr_next, mask_reg, mask_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic acc, wr_done, mapped, stall;
  logic hit_ctrl, hit_data, hit_saddr, hit_mask, hit_sec;
  logic [7:0] rd_byte;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic nine;

  assign mode = sumc_pkg::sumc_mode_t'({ctrl_reg.mode_select_low,
                                        ctrl_reg.mode_select_high}); // [RULE4]
  assign nine = (mode == sumc_pkg::MODE_UART9F) ||
                (mode == sumc_pkg::MODE_UART9V);

  // APB decode
  assign acc = psel & penable;
  assign hit_ctrl = (paddr[11:2] == sumc_pkg::IDX_MODE_CTRL);
  assign hit_data = (paddr[11:2] == sumc_pkg::IDX_DATA);
  assign hit_saddr = (paddr[11:2] == sumc_pkg::IDX_SLAVE_ADDR);
  assign hit_mask = (paddr[11:2] == sumc_pkg::IDX_ADDR_MASK);
  assign hit_sec = (paddr[11:2] == sumc_pkg::IDX_SEC_CTRL);
  assign mapped = (paddr[1:0] == sumc_pkg::WORD_LANE) &&
                  (hit_ctrl | hit_data | hit_saddr | hit_mask | hit_sec);
  // Transmit write waits for buffer room
  assign stall = mapped & hit_data & pwrite & pstrb[0] & ~fifo_in_ready;
  assign wr_done = acc & pready_reg & pwrite & pstrb[0] & ~pslverr_reg;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = ctrl_reg;
      rd_byte[sumc_pkg::BIT_SHARED] = sec_reg.alt_view_select ?
                                      fe_reg : ctrl_reg.mode_select_low; // [RULE1] [RULE3]
    end else if (hit_data) begin
      rd_byte = rx_data_reg;
    end else if (hit_saddr) begin
      rd_byte = saddr_reg;
    end else if (hit_mask) begin
      rd_byte = mask_reg;
    end else if (hit_sec) begin
      rd_byte = {sec_reg, sumc_pkg::SEC_RSVD};
    end
  end

  always_comb begin
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (acc && !pready_reg && !stall) begin
      pready_next = 1'b1;
      pslverr_next = ~mapped;
      prdata_next = mapped ? {sumc_pkg::RDATA_PAD, rd_byte} : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // Transmit buffer
  sumc_fifo #(
    .W(sumc_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(wr_done & hit_data),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Rate generation
  logic [3:0] div_reg, div_next, div_last;
  logic half_reg, half_next;
  logic fix_tick, t1_tick, samp_rx, samp_tx, tx_start;

  assign div_last = (mode == sumc_pkg::MODE_SHIFT) ? sumc_pkg::SHIFT_CLK_LAST :
                    sec_reg.double_rate_bit ? sumc_pkg::FIX_LAST_FAST :
                    sumc_pkg::FIX_LAST_SLOW; // [RULE5] [RULE14]
  assign fix_tick = (div_reg >= div_last);
  // Timer 1 overflows are halved unless doubling is on
  assign t1_tick = timer1_ovf & (sec_reg.double_rate_bit | half_reg); // [RULE14]
  assign samp_rx = (mode == sumc_pkg::MODE_UART9F) ? fix_tick :
                   sec_reg.rx_timer2_sel ? timer2_ovf : t1_tick;
  assign samp_tx = (mode == sumc_pkg::MODE_UART9F) ? fix_tick :
                   sec_reg.tx_timer2_sel ? timer2_ovf : t1_tick;

  always_comb begin
    div_next = (tx_start || fix_tick) ? sumc_pkg::DIV_ZERO : div_reg + 4'h1;
    half_next = timer1_ovf ? ~half_reg : half_reg;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= sumc_pkg::DIV_ZERO;
      half_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      half_reg <= half_next;
    end
  end

  // Transmit engine; also clocks shift-mode reception
  sumc_pkg::sumc_tx_t tx_state_reg, tx_state_next;
  logic [10:0] tx_shift_reg, tx_shift_next;
  logic [3:0] tx_left_reg, tx_left_next, tx_sub_reg, tx_sub_next;
  logic tx_pin_reg, tx_pin_next, rxo_reg, rxo_next, rxoe_reg, rxoe_next;
  logic m0_reg, m0_next, m0rx_reg, m0rx_next;
  logic tx_evt, m0_rx_evt, bit_tick;
  logic [7:0] m0_byte;

  assign fifo_out_ready = (tx_state_reg == sumc_pkg::TX_IDLE);
  assign tx_start = fifo_out_ready & (fifo_out_valid |
                    ((mode == sumc_pkg::MODE_SHIFT) &
                     ctrl_reg.receiver_enable & ~ctrl_reg.rx_done_flag));
  assign bit_tick = m0_reg ? fix_tick :
                    (samp_tx & (tx_sub_reg == sumc_pkg::SUB_LAST));
  assign m0_byte = {second_rx_pin_in, tx_shift_reg[7:1]};

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_left_next = tx_left_reg;
    tx_sub_next = tx_sub_reg;
    tx_pin_next = tx_pin_reg;
    rxo_next = rxo_reg;
    rxoe_next = rxoe_reg;
    m0_next = m0_reg;
    m0rx_next = m0rx_reg;
    tx_evt = 1'b0;
    m0_rx_evt = 1'b0;
    case (tx_state_reg)
      sumc_pkg::TX_IDLE: begin
        tx_pin_next = 1'b1;
        rxoe_next = 1'b0;
        tx_sub_next = sumc_pkg::DIV_ZERO;
        if (tx_start) begin
          tx_state_next = sumc_pkg::TX_RUN;
          tx_pin_next = 1'b0;
          m0_next = (mode == sumc_pkg::MODE_SHIFT);
          m0rx_next = ~fifo_out_valid;
          if (mode == sumc_pkg::MODE_SHIFT) begin
            tx_left_next = sumc_pkg::BITS_SHIFT;
            tx_shift_next = {3'h0, fifo_out_data};
            rxo_next = fifo_out_data[0];
            rxoe_next = fifo_out_valid;
          end else if (nine) begin
            tx_left_next = sumc_pkg::FRAME9;
            tx_shift_next = {1'b1, ctrl_reg.tx_ninth_bit,
                             fifo_out_data, 1'b0}; // [RULE9] [RULE15]
          end else begin
            tx_left_next = sumc_pkg::FRAME8;
            tx_shift_next = {2'h3, fifo_out_data, 1'b0}; // [RULE15]
          end
        end
      end
      sumc_pkg::TX_RUN: begin
        if (m0_reg) begin
          tx_pin_next = (div_reg >= sumc_pkg::SHIFT_CLK_HALF);
        end else if (samp_tx) begin
          tx_sub_next = tx_sub_reg + 4'h1;
        end
        if (bit_tick) begin
          tx_left_next = tx_left_reg - 4'h1;
          if (m0_reg) begin
            tx_shift_next = m0rx_reg ? {3'h0, m0_byte} :
                            {1'b0, tx_shift_reg[10:1]};
            rxo_next = tx_shift_reg[1];
            if (tx_left_reg == sumc_pkg::LEFT_STOP) begin
              tx_state_next = sumc_pkg::TX_IDLE;
              tx_pin_next = 1'b1;
              rxoe_next = 1'b0;
              tx_evt = ~m0rx_reg; // [RULE11]
              m0_rx_evt = m0rx_reg;
            end
          end else begin
            tx_shift_next = {1'b1, tx_shift_reg[10:1]};
            tx_pin_next = tx_shift_reg[1];
            // Flag rises as the stop bit starts
            tx_evt = (tx_left_reg == sumc_pkg::LEFT_PRE_STOP); // [RULE11]
            if (tx_left_reg == sumc_pkg::LEFT_STOP) begin
              tx_state_next = sumc_pkg::TX_IDLE;
              tx_pin_next = 1'b1;
            end
          end
        end
      end
      default: begin
        tx_state_next = sumc_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= sumc_pkg::TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_left_reg <= sumc_pkg::DIV_ZERO;
      tx_sub_reg <= sumc_pkg::DIV_ZERO;
      tx_pin_reg <= 1'b1;
      rxo_reg <= 1'b1;
      rxoe_reg <= 1'b0;
      m0_reg <= 1'b0;
      m0rx_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_shift_reg <= tx_shift_next;
      tx_left_reg <= tx_left_next;
      tx_sub_reg <= tx_sub_next;
      tx_pin_reg <= tx_pin_next;
      rxo_reg <= rxo_next;
      rxoe_reg <= rxoe_next;
      m0_reg <= m0_next;
      m0rx_reg <= m0rx_next;
    end
  end

  assign second_tx_pin = tx_pin_reg;
  assign second_rx_pin_out = rxo_reg;
  assign second_rx_pin_oe = rxoe_reg;

  // Asynchronous receiver
  sumc_pkg::sumc_rx_t rx_state_reg, rx_state_next;
  logic [8:0] rx_shift_reg, rx_shift_next;
  logic [3:0] rx_left_reg, rx_left_next, rx_sub_reg, rx_sub_next;
  logic rx_prev_reg, rx_fin, rx_on, accept;
  logic [7:0] rx_byte;
  logic rx_ninth;

  assign rx_on = ctrl_reg.receiver_enable &
                 (mode != sumc_pkg::MODE_SHIFT); // [RULE8]
  assign rx_byte = nine ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
  assign rx_ninth = nine ? rx_shift_reg[8] : second_rx_pin_in; // [RULE13]

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_shift_next = rx_shift_reg;
    rx_left_next = rx_left_reg;
    rx_sub_next = samp_rx ? rx_sub_reg + 4'h1 : rx_sub_reg;
    rx_fin = 1'b0;
    case (rx_state_reg)
      sumc_pkg::RX_IDLE: begin
        rx_sub_next = sumc_pkg::DIV_ZERO;
        if (rx_on && rx_prev_reg && !second_rx_pin_in) begin
          rx_state_next = sumc_pkg::RX_START;
        end
      end
      sumc_pkg::RX_START: begin
        if (samp_rx && rx_sub_reg == sumc_pkg::SUB_MID) begin
          rx_sub_next = sumc_pkg::DIV_ZERO;
          rx_left_next = nine ? sumc_pkg::RX_LEFT9 : sumc_pkg::RX_LEFT8;
          rx_state_next = second_rx_pin_in ? sumc_pkg::RX_IDLE :
                          sumc_pkg::RX_BITS;
        end
      end
      sumc_pkg::RX_BITS: begin
        if (samp_rx && rx_sub_reg == sumc_pkg::SUB_LAST) begin
          rx_left_next = rx_left_reg - 4'h1;
          if (rx_left_reg == sumc_pkg::LEFT_STOP) begin
            rx_fin = 1'b1;
            rx_state_next = sumc_pkg::RX_IDLE;
          end else begin
            rx_shift_next = {second_rx_pin_in, rx_shift_reg[8:1]}; // [RULE15]
          end
        end
      end
      default: begin
        rx_state_next = sumc_pkg::RX_IDLE;
      end
    endcase
    if (!rx_on) begin
      rx_state_next = sumc_pkg::RX_IDLE; // [RULE8]
      rx_fin = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_reg <= sumc_pkg::RX_IDLE;
      rx_shift_reg <= 9'h000;
      rx_left_reg <= sumc_pkg::DIV_ZERO;
      rx_sub_reg <= sumc_pkg::DIV_ZERO;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_shift_reg <= rx_shift_next;
      rx_left_reg <= rx_left_next;
      rx_sub_reg <= rx_sub_next;
      rx_prev_reg <= second_rx_pin_in;
    end
  end

  // Address recognition
  logic [7:0] bcast;
  logic match;

  assign bcast = saddr_reg | mask_reg;
  assign match = ((rx_byte & mask_reg) == (saddr_reg & mask_reg)) ||
                 ((rx_byte & bcast) == bcast); // [RULE7]
  always_comb begin
    accept = 1'b1;
    if (ctrl_reg.multiproc_enable) begin // [RULE6]
      accept = nine ? (rx_ninth | match) : second_rx_pin_in; // [RULE16] [RULE7]
    end
  end

  // Register file; hardware sets win over software writes
  always_comb begin
    ctrl_next = ctrl_reg;
    fe_next = fe_reg;
    sec_next = sec_reg;
    saddr_next = saddr_reg;
    mask_next = mask_reg;
    rx_data_next = rx_data_reg;
    if (wr_done && hit_ctrl) begin
      ctrl_next = sumc_pkg::sumc_ctrl_t'(pwdata[7:0]);
      if (sec_reg.alt_view_select) begin
        ctrl_next.mode_select_low = ctrl_reg.mode_select_low;
        fe_next = fe_reg & pwdata[sumc_pkg::BIT_SHARED]; // [RULE1] [RULE2]
      end
    end
    if (wr_done && hit_sec) begin
      sec_next = sumc_pkg::sumc_sec_t'(pwdata[7:4]);
    end
    if (wr_done && hit_saddr) begin
      saddr_next = pwdata[7:0];
    end
    if (wr_done && hit_mask) begin
      mask_next = pwdata[7:0];
    end
    if (tx_evt) begin
      ctrl_next.tx_done_flag = 1'b1; // [RULE11]
    end
    if (rx_fin && !second_rx_pin_in) begin
      fe_next = 1'b1; // [RULE1] [RULE2]
    end
    if (rx_fin && accept) begin
      ctrl_next.rx_done_flag = 1'b1; // [RULE12] [RULE16]
      ctrl_next.rx_ninth_bit = rx_ninth; // [RULE13]
      rx_data_next = rx_byte;
    end
    if (m0_rx_evt) begin
      ctrl_next.rx_done_flag = 1'b1; // [RULE12]
      rx_data_next = m0_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= sumc_pkg::MODE_CTRL_RST; // [RULE10]
      fe_reg <= 1'b0; // [RULE10]
      sec_reg <= sumc_pkg::SEC_CTRL_RST;
      saddr_reg <= sumc_pkg::SLAVE_ADDR_RST;
      mask_reg <= sumc_pkg::ADDR_MASK_RST;
      rx_data_reg <= sumc_pkg::RX_DATA_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      fe_reg <= fe_next;
      sec_reg <= sec_next;
      saddr_reg <= saddr_next;
      mask_reg <= mask_next;
      rx_data_reg <= rx_data_next;
    end
  end

endmodule

// ---- bench/sumc_top_assertions.sv ----
`timescale 1ns/1ps
module sumc_top_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Baud sources and pins
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic second_tx_pin,
  input wire logic second_rx_pin_in,
  input wire logic second_rx_pin_out,
  input wire logic second_rx_pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  localparam logic [11:0] A_MODE = 12'h268;
  logic mapped;
  logic wrote_reg;
  assign mapped = paddr inside {12'h268, 12'h26c, 12'h2a8, 12'h2e8, 12'h23c};
  // Mode register untouched by software since reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrote_reg <= 1'b0;
    end else if (pready && pwrite && paddr == A_MODE) begin
      wrote_reg <= 1'b1;
    end
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_low5;
    !second_tx_pin [*5];
  endsequence
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_cause;
    pready |-> s_access ##0 $past(penable);
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  property p_unmapped;
    pready |-> pslverr == !mapped;
  endproperty
  property p_rst_val;
    pready && !pwrite && paddr == A_MODE && !wrote_reg
      |-> prdata[7:0] == 8'h00;
  endproperty
  property p_idle_rst;
    $rose(nrst) |-> second_tx_pin && second_rx_pin_out &&
      !second_rx_pin_oe;
  endproperty
  property p_start_low;
    $fell(second_tx_pin) |=> s_low5;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready high two cycles");
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without access phase");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read data not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("pslverr does not match address map");
  a_rst_val: assert property (p_rst_val)
    else $error("mode reg not zero after reset");
  a_idle_rst: assert property (p_idle_rst)
    else $error("pins not idle after reset");
  a_start_low: assert property (p_start_low)
    else $error("tx low phase too short");
endmodule
bind sumc_top sumc_top_assertions sumc_top_assertions_inst (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
  .second_tx_pin(second_tx_pin), .second_rx_pin_in(second_rx_pin_in),
  .second_rx_pin_out(second_rx_pin_out),
  .second_rx_pin_oe(second_rx_pin_oe));

// ---- bench/sumc_peer.sv ----
`timescale 1ns/1ps
module sumc_peer #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input wire logic ref_clk,
  // Serial lines
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // Start, nine data bits LSB first, stop; idles high after
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = {stop, d, 1'b0};
    @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
  endtask
  task automatic grab(output logic [8:0] d, output logic ok);
    int n;
    n = 0;
    while (tx_line !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    ok = n < 5000;
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      d[i] = tx_line;
    end
    repeat (BIT_CLKS) @(posedge ref_clk);
    ok = ok && tx_line === 1'b1;
  endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic timer1_ovf, timer2_ovf, tx_pin, rx_out, rx_oe, peer_line, rx_wire;
  logic [7:0] rd_v;
  logic err_v, ok;
  logic [8:0] cap;
  int err_count, compares, cycles;
  localparam logic [11:0] A_MODE = {sumc_pkg::IDX_MODE_CTRL, 2'h0};
  localparam logic [11:0] A_DATA = {sumc_pkg::IDX_DATA, 2'h0};
  localparam logic [11:0] A_SLV = {sumc_pkg::IDX_SLAVE_ADDR, 2'h0};
  localparam logic [11:0] A_MSK = {sumc_pkg::IDX_ADDR_MASK, 2'h0};
  localparam logic [11:0] A_SEC = {sumc_pkg::IDX_SEC_CTRL, 2'h0};
  assign rx_wire = rx_oe ? rx_out : peer_line;
  sumc_top sumc_top_inst (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
    .second_tx_pin(tx_pin), .second_rx_pin_in(rx_wire),
    .second_rx_pin_out(rx_out), .second_rx_pin_oe(rx_oe));
  sumc_peer sumc_peer_inst (.ref_clk(ref_clk), .tx_line(tx_pin),
    .rx_line(peer_line));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Timer 1 overflows every second cycle
  always @(posedge ref_clk) begin
    timer1_ovf <= nrst & ~timer1_ovf;
  end
  task automatic complete_run;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 1000);
    rd_v = prdata[7:0];
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 1000) begin
      err_count++;
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({24'h000000, rd_v}, {24'h000000, e});
  endtask
  task automatic t_reset;
    rdchk(A_MODE, 8'h00);
    rdchk(A_SEC, 8'h00);
    apb(1'b0, 12'h100, 8'h00);
    chk({31'h0, err_v}, 32'h1);
  endtask
  task automatic t_tx;
    apb(1'b1, A_SEC, 8'h80);
    apb(1'b1, A_MODE, 8'h98);
    rdchk(A_MODE, 8'h98);
    apb(1'b1, A_DATA, 8'ha5);
    apb(1'b1, A_DATA, 8'h5a);
    sumc_peer_inst.grab(cap, ok);
    chk({23'h0, cap}, 32'h1a5);
    sumc_peer_inst.grab(cap, ok);
    chk({23'h0, cap}, 32'h15a);
    chk({31'h0, ok}, 32'h1);
    rdchk(A_MODE, 8'h9a);
    apb(1'b1, A_MODE, 8'h98);
    rdchk(A_MODE, 8'h98);
  endtask
  task automatic t_rx;
    sumc_peer_inst.send(9'h03c, 1'b1);
    rdchk(A_MODE, 8'h99);
    rdchk(A_DATA, 8'h3c);
    sumc_peer_inst.send(9'h15a, 1'b0);
    rdchk(A_MODE, 8'h9d);
    apb(1'b1, A_SEC, 8'hc0);
    sumc_peer_inst.send(9'h011, 1'b1);
    rdchk(A_MODE, 8'h99);
    apb(1'b1, A_MODE, 8'h18);
    rdchk(A_MODE, 8'h18);
    apb(1'b1, A_SEC, 8'h80);
    rdchk(A_MODE, 8'h98);
  endtask
  task automatic t_mp;
    apb(1'b1, A_SLV, 8'h42);
    apb(1'b1, A_MSK, 8'hff);
    apb(1'b1, A_MODE, 8'hb8);
    sumc_peer_inst.send(9'h013, 1'b1);
    rdchk(A_MODE, 8'hb8);
    sumc_peer_inst.send(9'h042, 1'b1);
    rdchk(A_MODE, 8'hb9);
    rdchk(A_DATA, 8'h42);
    apb(1'b1, A_MODE, 8'h88);
    sumc_peer_inst.send(9'h077, 1'b1);
    rdchk(A_MODE, 8'h88);
    rdchk(A_DATA, 8'h42);
  endtask
  task automatic t_m1;
    apb(1'b1, A_MODE, 8'h50);
    sumc_peer_inst.send(9'h1c3, 1'b1);
    rdchk(A_MODE, 8'h55);
    rdchk(A_DATA, 8'hc3);
    apb(1'b1, A_DATA, 8'h3c);
    sumc_peer_inst.grab(cap, ok);
    chk({23'h0, cap}, 32'h13c);
  endtask
  task automatic t_m0;
    logic [7:0] s;
    apb(1'b1, A_MODE, 8'h00);
    apb(1'b1, A_DATA, 8'h96);
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_pin);
      s[i] = rx_out;
    end
    chk({24'h0, s}, 32'h96);
    repeat (8) @(posedge ref_clk);
    rdchk(A_MODE, 8'h02);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    timer2_ovf = 1'b0;
    err_count = 0;
    compares = 0;
    cycles = 0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_mp();
    t_m1();
    t_m0();
    complete_run();
  end
endmodule
